// *** flash_cmd_core.sv ***
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// R01 - Either whole-array erase opcode drives the array to all ones.
// R02 - Whole-array erase is taken only while write enable latch is set.
// R03 - Erase frame must end exactly after eight bits, else discarded.
// R04 - Erase runs for chip erase time; busy reads one meanwhile.
// R05 - Finished whole-array erase clears the write enable latch.
// R06 - Any block protect bit set refuses the whole-array erase.
// R07 - Power-down opcode then chip select rise enters low power in time.
// R08 - Power-down frame longer or shorter than eight bits is ignored.
// R09 - While powered down only the release opcode is recognised.
// R10 - Reset always starts in normal operation, never powered down.
// R11 - Release-only frame wakes after first wake time, then accepts commands.
// R12 - Release opcode plus three dummy bytes streams device ID repeatedly.
// R13 - Release with ID from power-down wakes after second wake time.
// R14 - Release opcode while busy is ignored, erase continues untouched.
// R15 - Opcode 90h with address zero streams manufacturer then device ID.
// R16 - Address one swaps order; both IDs alternate until chip select rises.
// R17 - Standard ID opcode streams manufacturer, memory type, capacity bytes.
// R18 - Host shifts opcodes and addresses in on serial input while selected.
// R19 - Input bits sampled on rising serial clock, MSB first, from select.
// R20 - Erase, entry and wake times are parameters, counted in clocks.
module flash_cmd_core import flash_pkg::*; #(
  parameter int CHIP_ERASE_TIME_NS = 10000000,
  parameter int POWER_DOWN_ENTRY_TIME_NS = 3000,
  parameter int RELEASE_WAKE_TIME_NS = 3000,
  parameter int RELEASE_ID_WAKE_TIME_NS = 1800,
  // Identity values below are arbitrary
  parameter logic [7:0] MFR_ID = 8'h5a,
  parameter logic [7:0] DEV_ID = 8'h3c,
  parameter logic [7:0] MEM_TYPE = 8'h40,
  parameter logic [7:0] CAPACITY = 8'h16
) (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Protection inputs
  input wire logic block_protect_bit2,
  input wire logic block_protect_bit1,
  input wire logic block_protect_bit0,
  // Status outputs
  output logic busy,
  output logic write_enable_latch,
  output logic power_down,
  output logic array_erase
);

  // ==========================================================
  // Timing counts, all times rounded down, at least one cycle
  localparam int ERASE_RAW = CHIP_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int ENTRY_RAW = POWER_DOWN_ENTRY_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE1_RAW = RELEASE_WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE2_RAW = RELEASE_ID_WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_RAW < 1) ? 1 : ERASE_RAW;
  localparam int ENTRY_CYCLES = (ENTRY_RAW < 1) ? 1 : ENTRY_RAW;
  localparam int WAKE1_CYCLES = (WAKE1_RAW < 1) ? 1 : WAKE1_RAW;
  localparam int WAKE2_CYCLES = (WAKE2_RAW < 1) ? 1 : WAKE2_RAW;
  localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYCLES - 1);
  localparam logic [CNT_W-1:0] ENTRY_LOAD = CNT_W'(ENTRY_CYCLES - 1);
  localparam logic [CNT_W-1:0] WAKE1_LOAD = CNT_W'(WAKE1_CYCLES - 1);
  localparam logic [CNT_W-1:0] WAKE2_LOAD = CNT_W'(WAKE2_CYCLES - 1);

  // ==========================================================
  // Per-opcode stream shape
  function automatic logic [5:0] op_header(input logic [7:0] op);
    logic [5:0] h;
    h = BITS_MAX;
    if (op == OP_READ_STATUS || op == OP_STD_ID) begin
      h = BITS_OPCODE;
    end else if (op == OP_RELEASE_ID || op == OP_MFR_DEV_ID) begin
      h = BITS_ADDR_HDR;
    end
    return h;
  endfunction

  function automatic logic [4:0] op_period(input logic [7:0] op);
    logic [4:0] p;
    p = PERIOD_BYTE;
    if (op == OP_MFR_DEV_ID) begin
      p = PERIOD_PAIR;
    end else if (op == OP_STD_ID) begin
      p = PERIOD_TRIPLE;
    end
    return p;
  endfunction

  // ==========================================================
  // Link side, rising edges: input shifter, cleared while deselected
  typedef struct packed {
    logic [BIT_CNT_W-1:0] bits;
    logic [6:0] shreg;
    logic [7:0] opcode;
    logic addr_lsb;
    logic [POS_W-1:0] pos;
  } rx_s;

  rx_s rx;
  rx_s next_rx;
  logic [5:0] hdr;
  logic [4:0] period;

  always_comb begin
    next_rx = rx;
    hdr = op_header(rx.opcode);
    period = op_period(rx.opcode);
    if (rx.bits != BITS_MAX) begin
      next_rx.bits = rx.bits + 6'h01;
    end
    next_rx.shreg = {rx.shreg[5:0], si}; // R18 R19
    if (rx.bits == BITS_OPCODE - 6'h01) begin
      next_rx.opcode = {rx.shreg, si}; // R19
    end
    if (rx.bits == BITS_ADDR_LSB) begin
      next_rx.addr_lsb = si;
    end
    // Position wraps so the stream repeats until deselect
    if (rx.bits < hdr) begin
      next_rx.pos = '0;
    end else if (rx.pos == period - 5'h01) begin
      next_rx.pos = '0; // R12 R16
    end else begin
      next_rx.pos = rx.pos + 5'h01;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // ==========================================================
  // Frame record: survives deselect so the system side can read it
  // once chip select is seen high; sclk is idle then.
  typedef struct packed {
    logic [7:0] opcode;
    logic [BIT_CNT_W-1:0] bits;
    logic frame_tog;
  } rec_s;

  rec_s rec;
  rec_s next_rec;

  always_comb begin
    next_rec = rec;
    next_rec.opcode = next_rx.opcode;
    next_rec.bits = next_rx.bits;
    if (rx.bits == BITS_NONE) begin
      next_rec.frame_tog = ~rec.frame_tog;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rec <= '0;
    end else begin
      rec <= next_rec;
    end
  end

  // ==========================================================
  // Status levels into the link domain
  logic [SY_W-1:0] sy_src;
  logic [SY_W-1:0] sy;

  flash_sync2 #(
    .WIDTH(SY_W),
    .RESET_VAL(SY_RESET)
  ) u_status_sync (
    .clk(sclk),
    .arst(cs_n),
    .d(sy_src),
    .q(sy)
  );

  // ==========================================================
  // Link side, falling edges: serial output
  typedef struct packed {
    logic data;
    logic oe;
  } tx_s;

  tx_s tx;
  tx_s next_tx;
  logic [23:0] stream;
  logic allowed;
  logic [7:0] status_byte;

  always_comb begin
    next_tx = tx;
    status_byte = 8'h00;
    status_byte[STATUS_BUSY_BIT] = sy[SY_BUSY]; // R04
    status_byte[STATUS_LATCH_BIT] = sy[SY_LATCH];
    stream = '0;
    allowed = 1'b0;
    if (rx.opcode == OP_RELEASE_ID) begin
      stream = {DEV_ID, 16'h0000}; // R12
      allowed = ~sy[SY_BUSY] & ~sy[SY_WAKE]; // R14
    end else if (rx.opcode == OP_MFR_DEV_ID) begin
      stream = rx.addr_lsb ? {DEV_ID, MFR_ID, 8'h00} : {MFR_ID, DEV_ID, 8'h00}; // R15 R16
      allowed = ~sy[SY_BUSY] & ~sy[SY_SLEEP] & ~sy[SY_WAKE]; // R09
    end else if (rx.opcode == OP_STD_ID) begin
      stream = {MFR_ID, MEM_TYPE, CAPACITY}; // R17
      allowed = ~sy[SY_BUSY] & ~sy[SY_SLEEP] & ~sy[SY_WAKE]; // R09
    end else if (rx.opcode == OP_READ_STATUS) begin
      stream = {status_byte, 16'h0000}; // R04
      allowed = ~sy[SY_SLEEP] & ~sy[SY_WAKE]; // R09
    end
    next_tx.oe = allowed & (rx.bits >= hdr);
    next_tx.data = next_tx.oe & stream[STREAM_MSB - rx.pos];
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx <= '0;
    end else begin
      tx <= next_tx;
    end
  end

  assign so = tx.data;
  assign so_oe = tx.oe;

  // ==========================================================
  // System side: frame end detection
  logic [1:0] fx;

  flash_sync2 #(
    .WIDTH(2),
    .RESET_VAL(FX_RESET)
  ) u_frame_sync (
    .clk(mclk),
    .arst(rst),
    .d({cs_n, rec.frame_tog}),
    .q(fx)
  );

  // ==========================================================
  // System side: command execution and self-timed cycles
  typedef struct packed {
    dev_state_e state;
    logic [CNT_W-1:0] cnt;
    logic wr_latch;
    logic cs_prev;
    logic seen_tog;
  } dev_s;

  dev_s dev;
  dev_s next_dev;
  logic frame_end;
  logic fresh;
  logic exact8;
  logic is_release;
  logic protect_any;

  always_comb begin
    next_dev = dev;
    next_dev.cs_prev = fx[FX_CS];
    frame_end = fx[FX_CS] & ~dev.cs_prev;
    // A frame with no clock edges leaves the toggle alone and is dropped
    fresh = frame_end & (fx[FX_TOG] != dev.seen_tog);
    if (frame_end) begin
      next_dev.seen_tog = fx[FX_TOG];
    end
    exact8 = rec.bits == BITS_OPCODE; // R03 R08
    is_release = fresh & (rec.opcode == OP_RELEASE_ID) & (rec.bits >= BITS_OPCODE);
    protect_any = block_protect_bit2 | block_protect_bit1 | block_protect_bit0;
    if (dev.cnt != '0) begin
      next_dev.cnt = dev.cnt - CNT_W'(1);
    end
    case (dev.state)
      ST_IDLE: begin
        if (fresh & exact8) begin
          if (rec.opcode == OP_WRITE_ENABLE) begin
            next_dev.wr_latch = 1'b1;
          end else if (rec.opcode == OP_WRITE_DISABLE) begin
            next_dev.wr_latch = 1'b0;
          end else if (rec.opcode == OP_ERASE_ALL_A || rec.opcode == OP_ERASE_ALL_B) begin
            if (dev.wr_latch & ~protect_any) begin // R02 R06
              next_dev.state = ST_ERASE; // R01 R03
              next_dev.cnt = ERASE_LOAD; // R04 R20
            end
          end else if (rec.opcode == OP_POWER_DOWN) begin
            next_dev.state = ST_PD_ENTRY; // R07 R08
            next_dev.cnt = ENTRY_LOAD; // R20
          end
        end
      end
      ST_ERASE: begin
        // Every command but status read ignored while busy, release included
        if (dev.cnt == '0) begin // R14
          next_dev.state = ST_IDLE; // R04
          next_dev.wr_latch = 1'b0; // R05
        end
      end
      ST_PD_ENTRY, ST_ASLEEP: begin
        if (is_release) begin // R09
          next_dev.state = ST_WAKE;
          next_dev.cnt = exact8 ? WAKE1_LOAD : WAKE2_LOAD; // R11 R13 R20
        end else if (dev.state == ST_PD_ENTRY && dev.cnt == '0) begin
          next_dev.state = ST_ASLEEP; // R07
        end
      end
      ST_WAKE: begin
        // Commands stay locked out until the wake time has run
        if (dev.cnt == '0) begin
          next_dev.state = ST_IDLE; // R11 R13
        end
      end
      default: begin
        next_dev.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dev.state <= ST_IDLE; // R10
      dev.cnt <= '0;
      dev.wr_latch <= 1'b0;
      dev.cs_prev <= 1'b1;
      dev.seen_tog <= 1'b0;
    end else begin
      dev <= next_dev;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    sy_src = '0;
    sy_src[SY_BUSY] = dev.state == ST_ERASE;
    sy_src[SY_LATCH] = dev.wr_latch;
    sy_src[SY_SLEEP] = (dev.state == ST_PD_ENTRY) | (dev.state == ST_ASLEEP);
    sy_src[SY_WAKE] = dev.state == ST_WAKE;
  end

  assign busy = dev.state == ST_ERASE; // R04
  assign array_erase = dev.state == ST_ERASE; // R01
  assign write_enable_latch = dev.wr_latch;
  assign power_down = dev.state == ST_ASLEEP; // R07

endmodule

`default_nettype wire

// *** flash_pkg.sv ***
package flash_pkg;

  // ==========================================================
  // Instruction opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_ERASE_ALL_A = 8'hc7;
  localparam logic [7:0] OP_ERASE_ALL_B = 8'h60;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE_ID = 8'hab;
  localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;
  localparam logic [7:0] OP_STD_ID = 8'h9f;

  // ==========================================================
  // Frame bit counting
  localparam int BIT_CNT_W = 6;
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR_HDR = 6'h20;
  localparam logic [5:0] BITS_ADDR_LSB = 6'h1f;
  localparam logic [5:0] BITS_MAX = 6'h3f;
  localparam logic [5:0] BITS_NONE = 6'h00;

  // ==========================================================
  // Output stream periods, first byte sits in bits 23:16
  localparam int POS_W = 5;
  localparam logic [4:0] PERIOD_BYTE = 5'h08;
  localparam logic [4:0] PERIOD_PAIR = 5'h10;
  localparam logic [4:0] PERIOD_TRIPLE = 5'h18;
  localparam logic [4:0] STREAM_MSB = 5'h17;

  // ==========================================================
  // Status byte layout and status levels passed to the link side
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_LATCH_BIT = 1;
  localparam int SY_W = 4;
  localparam int SY_BUSY = 0;
  localparam int SY_LATCH = 1;
  localparam int SY_SLEEP = 2;
  localparam int SY_WAKE = 3;
  localparam logic [3:0] SY_RESET = 4'h0;

  // Frame crossing: bit 1 chip select, bit 0 frame toggle
  localparam int FX_CS = 1;
  localparam int FX_TOG = 0;
  localparam logic [1:0] FX_RESET = 2'h2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CNT_W = 32;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ERASE = 5'b00010,
    ST_PD_ENTRY = 5'b00100,
    ST_ASLEEP = 5'b01000,
    ST_WAKE = 5'b10000
  } dev_state_e;

endpackage

// *** flash_sync2.sv ***
`timescale 1ns/10ps
`default_nettype none

module flash_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic arst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s r;
  sync_s next_r;

  always_comb begin
    next_r = r;
    next_r.meta = d;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      r <= {RESET_VAL, RESET_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign q = r.stable;

endmodule

`default_nettype wire

// *** flash_cmd_core_sva.sv ***
`timescale 1ns/10ps
`default_nettype none

module flash_cmd_core_sva import flash_pkg::*; #(
  parameter int CHIP_ERASE_TIME_NS = 10000000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial link
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe,
  // Protection and status
  input wire logic block_protect_bit2,
  input wire logic block_protect_bit1,
  input wire logic block_protect_bit0,
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic power_down,
  input wire logic array_erase
);
  // ==========================================================
  // Erase length counter
  localparam int ECYC = CHIP_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ECYC < 1) ? 1 : ECYC;
  logic [CNT_W-1:0] busy_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_cnt <= '0;
    end else if (busy) begin
      busy_cnt <= busy_cnt + 1'b1;
    end else begin
      busy_cnt <= '0;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_erase_len; $fell(busy) |-> busy_cnt == ERASE_CYC; endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length off");
  property p_erase_wel; $rose(busy) |-> write_enable_latch && array_erase; endproperty
  a_erase_wel: assert property (p_erase_wel) else $error("erase without latch");
  property p_erase_done; $fell(busy) |-> !write_enable_latch && !array_erase; endproperty
  a_erase_done: assert property (p_erase_done) else $error("latch kept");
  property p_protect;
    $rose(busy) |-> !$past(block_protect_bit2) && !$past(block_protect_bit1)
      && !$past(block_protect_bit0);
  endproperty
  a_protect: assert property (p_protect) else $error("protected erase ran");
  property p_array; array_erase |-> busy; endproperty
  a_array: assert property (p_array) else $error("erase flag without busy");
  property p_pd_entry; $rose(power_down) |-> cs_n && !busy; endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("bad sleep entry");
  property p_reset_normal; $past(rst) |-> !power_down && !busy; endproperty
  a_reset_normal: assert property (p_reset_normal) else $error("not normal at reset");
  property p_so_idle; cs_n |-> !so_oe && !so; endproperty
  a_so_idle: assert property (p_so_idle) else $error("output while deselected");
  // Latch must survive the whole cycle: no command may touch it while busy
  property p_busy_awake; busy |-> write_enable_latch && !power_down; endproperty
  a_busy_awake: assert property (p_busy_awake) else $error("state changed while busy");
endmodule

bind flash_cmd_core flash_cmd_core_sva #(.CHIP_ERASE_TIME_NS(CHIP_ERASE_TIME_NS)) u_sva (
  .mclk(mclk), .rst(rst), .cs_n(cs_n), .so(so), .so_oe(so_oe),
  .block_protect_bit2(block_protect_bit2), .block_protect_bit1(block_protect_bit1),
  .block_protect_bit0(block_protect_bit0), .busy(busy),
  .write_enable_latch(write_enable_latch), .power_down(power_down),
  .array_erase(array_erase)
);

`default_nettype wire

// *** spi_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ==========================================================
  // Frame: link clock runs only while selected
  task automatic xfer(input logic [71:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    #23;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #40;
      sclk = 1'b1;
      rx = {rx[30:0], so};
      #40;
      sclk = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    si = ~si;
    // Gap long enough for the end to be seen; wake times run on into the next frame
    #400;
  endtask
endmodule

`default_nettype wire

// *** serial_flash_erase_powerdown_id_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module serial_flash_erase_powerdown_id_test import flash_pkg::*;;
  // Identity values are arbitrary
  localparam logic [7:0] MFR = 8'h5a;
  localparam logic [7:0] DEV = 8'h3c;
  localparam logic [7:0] MEM = 8'h40;
  localparam logic [7:0] CAP = 8'h16;
  logic mclk, rst, sclk, cs_n, si, so, so_oe, busy, latch_on, pd, ae;
  logic [2:0] bp;
  logic [31:0] rx, seen;
  logic [31:0] exp_q[$];
  string name_q[$];
  event seen_ev;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] ops [2] = '{OP_ERASE_ALL_A, OP_ERASE_ALL_B};

  flash_cmd_core #(.CHIP_ERASE_TIME_NS(10000), .POWER_DOWN_ENTRY_TIME_NS(300),
    .RELEASE_WAKE_TIME_NS(400), .RELEASE_ID_WAKE_TIME_NS(500), .MFR_ID(MFR),
    .DEV_ID(DEV), .MEM_TYPE(MEM), .CAPACITY(CAP)) DUT (
    .mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .block_protect_bit2(bp[2]), .block_protect_bit1(bp[1]), .block_protect_bit0(bp[0]),
    .busy(busy), .write_enable_latch(latch_on), .power_down(pd), .array_erase(ae));
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  // ==========================================================
  // Checking
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    forever begin
      @(seen_ev);
      check(name_q.pop_front(), seen, exp_q.pop_front());
    end
  end

  // ==========================================================
  // Drivers
  task automatic frame(input string what, input logic [71:0] tx, input int n,
                       input logic [31:0] exp);
    name_q.push_back(what);
    exp_q.push_back(exp);
    host.xfer(tx, n, rx);
    seen = rx;
    ->seen_ev;
    #1;
  endtask
  task automatic cmd(input logic [71:0] tx, input int n);
    host.xfer(tx, n, rx);
  endtask
  // Flags packed as busy, latch, sleep, erase
  task automatic flags(input string what, input logic [3:0] exp);
    @(negedge mclk);
    name_q.push_back(what);
    exp_q.push_back({28'h0, exp});
    seen = {28'h0, busy, latch_on, pd, ae};
    ->seen_ev;
    #1;
  endtask
  task automatic wait_pd();
    for (int i = 0; i < 100 && pd !== 1'b1; i++) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    bp = 3'h0;
    void'($urandom(38630));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    flags("reset", 4'h0);
    frame("std id", {OP_STD_ID, 32'h0}, 40, {MFR, MEM, CAP, MFR});
    frame("id a0", {OP_MFR_DEV_ID, 56'h0}, 64, {MFR, DEV, MFR, DEV});
    frame("id a1", {OP_MFR_DEV_ID, 24'h1, 32'h0}, 64, {DEV, MFR, DEV, MFR});
    frame("dev id", {OP_RELEASE_ID, 24'($urandom), 16'h0}, 48, {16'h0, DEV, DEV});
    $display("test ids done");
    @(posedge mclk);
    bp <= 3'(1 + $urandom_range(6));
    cmd(OP_WRITE_ENABLE, 8);
    cmd(OP_ERASE_ALL_A, 8);
    frame("protected", {OP_READ_STATUS, 8'h0}, 16, 32'h2);
    @(posedge mclk);
    bp <= 3'h0;
    cmd({OP_ERASE_ALL_A, 1'b0}, 9);
    frame("long erase", {OP_READ_STATUS, 8'h0}, 16, 32'h2);
    foreach (ops[k]) begin
      cmd(OP_WRITE_DISABLE, 8);
      cmd(ops[k], 8);
      flags("no latch", 4'h0);
      cmd(OP_WRITE_ENABLE, 8);
      cmd(ops[k], 8);
      frame("erasing", {OP_READ_STATUS, 8'h0}, 16, 32'h3);
      frame("id busy", {OP_RELEASE_ID, 40'h0}, 48, 32'h0);
      flags("still busy", 4'hd);
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk);
      flags("erased", 4'h0);
    end
    $display("test erase done");
    cmd({OP_POWER_DOWN, 1'b1}, 9);
    flags("long sleep", 4'h0);
    cmd(OP_POWER_DOWN, 8);
    wait_pd();
    flags("asleep", 4'h2);
    frame("status asleep", {OP_READ_STATUS, 8'h0}, 16, 32'h0);
    frame("id asleep", {OP_STD_ID, 32'h0}, 40, 32'h0);
    cmd(OP_RELEASE_ID, 8);
    cmd(OP_WRITE_ENABLE, 8);
    frame("woken", {OP_READ_STATUS, 8'h0}, 16, 32'h2);
    cmd(OP_POWER_DOWN, 8);
    wait_pd();
    frame("wake id", {OP_RELEASE_ID, 40'h0}, 48, {16'h0, DEV, DEV});
    flags("wake id", 4'h4);
    cmd(OP_POWER_DOWN, 8);
    wait_pd();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    flags("reset sleep", 4'h0);
    $display("test power done");
    complete_run();
  end
endmodule

`default_nettype wire
